// ---- cmfl_top.v ----
// Purpose: message-slot front end: id layout, filtering, lock/busy
// Assumes: host and bus-side strobes synchronous to ref_clk
// Notes: 16 slots; slot contents held here, bit engine outside
`timescale 1ns/10ps
`default_nettype none
`include "cmfl_defines.vh"
module cmfl_top #(
  parameter FILL_CYCLES = 8
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // host slot access
  input wire host_wr,
  input wire host_rd,
  input wire [3:0] host_slot,
  input wire [1:0] host_word,
  input wire [15:0] host_wdata,
  output reg [15:0] host_rdata_ff,
  input wire host_timer_rd,
  // acceptance masks
  input wire [28:0] mask_global,
  input wire [28:0] mask_14,
  input wire [28:0] mask_15,
  // received frame from the bit engine
  input wire rx_frame_vld,
  input wire [28:0] rx_id,
  input wire rx_ide,
  input wire rx_srr,
  input wire rx_rtr,
  input wire [3:0] rx_len,
  input wire id_start,
  output reg rx_ready_ff,
  // rtr/srr bit compare during transmit arbitration
  input wire arb_chk,
  input wire arb_sent,
  input wire arb_seen,
  output reg arb_lost_ff,
  output reg bit_err_ff,
  // status
  output reg [3:0] lock_slot_ff,
  output reg lock_vld_ff,
  output reg [15:0] timer_ff
);
  localparam ST_IDLE = 2'h0;
  localparam ST_FILL = 2'h1;
  localparam ST_WAIT = 2'h2;
  // staged frame: slot, format, srr, rtr, len, id, timestamp
  localparam SW = 4 + 1 + 1 + 1 + 4 + 29 + 16;

  reg [15:0] upper_ff [0:15];
  reg [15:0] lower_ff [0:15];
  reg [3:0] code_ff [0:15];
  reg [3:0] len_ff [0:15];
  reg [15:0] ts_cap_ff;
  reg [1:0] st_ff;
  reg [4:0] fill_cnt_ff;
  reg [SW-1:0] cur_ff;

  // slot identifier as 29 bits from its two words
  function [28:0] slot_id;
    input [15:0] up;
    input [15:0] lo;
    begin
      if (up[`CMFL_HI_IDE])
        slot_id = {up[15:5], up[2:0], lo[15:1]};
      else
        slot_id = {up[15:5], 18'h00000};
    end
  endfunction

  function is_rx_active;
    input [3:0] c;
    begin
      is_rx_active = (c[3] == 1'b0) && (c[2:1] != 2'h0);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // acceptance per slot
  wire [15:0] hit;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : acc
      wire [28:0] m;
      assign m = (g == 14) ? mask_14 :
                 (g == 15) ? mask_15 : mask_global;
      wire [28:0] sid;
      assign sid = slot_id(upper_ff[g], lower_ff[g]);
      cmfl_accept u_acc (
        .rx_id(rx_id),
        .rx_ide(rx_ide),
        .slot_id(sid),
        .slot_ide(upper_ff[g][`CMFL_HI_IDE]),
        .mask(m),
        .hit(hit[g])
      );
    end
  endgenerate

  reg [3:0] pick;
  reg pick_vld;
  reg rtr_hit;
  reg [3:0] rtr_slot;
  integer k;
  always @* begin
    pick = 4'h0;
    pick_vld = 1'b0;
    rtr_hit = 1'b0;
    rtr_slot = 4'h0;
    // lowest slot wins; only active receive slots qualify
    for (k = 15; k >= 0; k = k - 1) begin
      if (hit[k] && is_rx_active(code_ff[k])) begin
        pick = k[3:0];
        pick_vld = 1'b1;
      end
      if (hit[k] && code_ff[k] == `CMFL_CODE_TX_RRESP) begin
        rtr_hit = 1'b1;
        rtr_slot = k[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // staging buffers
  wire stg_can_push;
  wire [SW-1:0] stg_head;
  wire stg_vld;
  wire stg_pop;
  wire [SW-1:0] stg_in;
  wire do_push;
  assign do_push = rx_frame_vld && pick_vld && !rx_rtr && stg_can_push;
  // the slot is chosen now, so later mask edits cannot drop it
  assign stg_in = {pick, rx_ide, rx_srr, rx_rtr, rx_len, rx_id,
                   ts_cap_ff};
  assign stg_pop = (st_ff == ST_IDLE) && stg_vld &&
                   !(lock_vld_ff && lock_slot_ff == stg_head[SW-1:SW-4]);
  cmfl_stage #(.W(SW)) u_stage (
    .ref_clk(ref_clk),
    .rst(rst),
    .push(do_push),
    .push_data(stg_in),
    .can_push(stg_can_push),
    .pop(stg_pop),
    .head_data(stg_head),
    .head_valid(stg_vld)
  );

  wire [3:0] c_slot;
  wire c_ide;
  wire c_srr;
  wire c_rtr;
  wire [3:0] c_len;
  wire [28:0] c_id;
  wire [15:0] c_ts;
  assign {c_slot, c_ide, c_srr, c_rtr, c_len, c_id, c_ts} = cur_ff;
  wire rd_status;
  assign rd_status = host_rd && host_word == 2'h0;
  wire rd_busy;
  assign rd_busy = (st_ff == ST_FILL) && c_slot == host_slot;

  ////////////////////////////////////////////////////////////////////////
  // slot storage, fill sequencer, lock
  integer i;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 16; i = i + 1) begin
        upper_ff[i] <= 16'h0000;
        lower_ff[i] <= 16'h0000;
        code_ff[i] <= 4'h0;
        len_ff[i] <= 4'h0;
      end
      st_ff <= ST_IDLE;
      fill_cnt_ff <= 5'h00;
      cur_ff <= {SW{1'b0}};
      lock_slot_ff <= 4'h0;
      lock_vld_ff <= 1'b0;
      host_rdata_ff <= 16'h0000;
      ts_cap_ff <= 16'h0000;
      timer_ff <= 16'h0000;
      rx_ready_ff <= 1'b0;
      arb_lost_ff <= 1'b0;
      bit_err_ff <= 1'b0;
    end else begin
      timer_ff <= timer_ff + 16'h0001;
      if (id_start)
        ts_cap_ff <= timer_ff;
      rx_ready_ff <= stg_can_push;
      // rtr/srr bit treatment
      arb_lost_ff <= arb_chk && arb_sent && !arb_seen;
      bit_err_ff <= arb_chk && !arb_sent && arb_seen;
      if (rx_frame_vld && rx_rtr && rtr_hit)
        code_ff[rtr_slot] <= `CMFL_CODE_TX_ONCE_RESP;
      // fill sequencer
      case (st_ff)
        ST_IDLE: begin
          if (stg_pop) begin
            cur_ff <= stg_head;
            st_ff <= ST_FILL;
            fill_cnt_ff <= 5'h00;
          end
        end
        ST_FILL: begin
          fill_cnt_ff <= fill_cnt_ff + 5'h01;
          // fill length is far below the busy limit
          if (fill_cnt_ff == FILL_CYCLES[4:0] - 5'h01) begin
            if (c_ide) begin
              upper_ff[c_slot] <= {c_id[28:18], c_srr, 1'b1,
                                   c_id[17:15]};
              lower_ff[c_slot] <= {c_id[14:0], c_rtr};
            end else begin
              upper_ff[c_slot] <= {c_id[28:18], c_rtr, 4'h0};
              lower_ff[c_slot] <= c_ts;
            end
            len_ff[c_slot] <= c_len;
            code_ff[c_slot] <= (code_ff[c_slot] == `CMFL_CODE_RX_EMPTY) ?
                               `CMFL_CODE_RX_FULL : `CMFL_CODE_RX_OVR;
            st_ff <= ST_WAIT;
          end
        end
        ST_WAIT: st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
      // host writes; status word writes activate or deactivate
      if (host_wr) begin
        case (host_word)
          2'h0: begin
            code_ff[host_slot] <= host_wdata[7:4];
            len_ff[host_slot] <= host_wdata[3:0];
          end
          2'h1: upper_ff[host_slot] <= host_wdata;
          2'h2: lower_ff[host_slot] <= host_wdata;
          default: ;
        endcase
      end
      // host reads and lock handling
      if (host_rd) begin
        case (host_word)
          2'h0: host_rdata_ff <= {c_ts[15:8] & {8{1'b0}},
                   code_ff[host_slot] | {3'h0, rd_busy},
                   len_ff[host_slot]};
          2'h1: host_rdata_ff <= upper_ff[host_slot];
          2'h2: host_rdata_ff <= lower_ff[host_slot];
          default: host_rdata_ff <= 16'h0000;
        endcase
      end else if (host_timer_rd) begin
        host_rdata_ff <= timer_ff;
      end
      if (host_timer_rd)
        lock_vld_ff <= 1'b0;
      if (rd_status && !code_ff[host_slot][3]) begin
        if (rd_busy) begin
          lock_vld_ff <= 1'b0;
        end else begin
          lock_slot_ff <= host_slot;
          lock_vld_ff <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- cmfl_defines.vh ----
// Purpose: constants for the message-slot front end
// Assumes: 40 MHz ref_clk
// Notes: codes are the 4-bit slot control/status codes
`ifndef CMFL_DEFINES_VH
`define CMFL_DEFINES_VH
`define CMFL_CODE_RX_OFF 4'h0
`define CMFL_CODE_RX_EMPTY 4'h4
`define CMFL_CODE_RX_FULL 4'h2
`define CMFL_CODE_RX_OVR 4'h6
`define CMFL_CODE_TX_OFF 4'h8
`define CMFL_CODE_TX_ONCE 4'hC
`define CMFL_CODE_TX_RRESP 4'hA
`define CMFL_CODE_TX_ONCE_RESP 4'hE
`define CMFL_SLOTS 16
`define CMFL_FILL_CYCLES 5'h08
`define CMFL_BUSY_MAX 5'h14
// id field positions inside the upper and lower identifier words
`define CMFL_HI_IDE 3
`define CMFL_HI_SRR 4
`define CMFL_HI_STD_RTR 4
`define CMFL_LO_EXT_RTR 0
`endif

// ---- cmfl_accept.v ----
// Purpose: masked identifier comparison of one message slot
// Assumes: identifiers as 29 bits plus format bit
// Notes: pure combinational
`timescale 1ns/10ps
`default_nettype none
module cmfl_accept (
  // frame
  input wire [28:0] rx_id,
  input wire rx_ide,
  // slot
  input wire [28:0] slot_id,
  input wire slot_ide,
  input wire [28:0] mask,
  // result
  output wire hit
);
  wire [28:0] diff;
  wire [28:0] eff_mask;
  // standard frames compare only the base identifier bits
  assign eff_mask = rx_ide ? mask : {mask[28:18], 18'h00000};
  assign diff = (rx_id ^ slot_id) & eff_mask;
  assign hit = (diff == 29'h00000000) && (rx_ide == slot_ide);
endmodule
`default_nettype wire

// ---- cmfl_stage.v ----
// Purpose: two hidden staging buffers for frames in flight
// Assumes: one frame written per push, one drained per pop
// Notes: ping-pong, only the active one fills at a time
`timescale 1ns/10ps
`default_nettype none
module cmfl_stage #(
  parameter W = 64
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // fill side
  input wire push,
  input wire [W-1:0] push_data,
  output wire can_push,
  // drain side
  input wire pop,
  output wire [W-1:0] head_data,
  output wire head_valid
);
  reg [W-1:0] buf_ff [0:1];
  reg [1:0] full_ff;
  reg wr_sel_ff;
  reg rd_sel_ff;
  assign can_push = ~full_ff[wr_sel_ff];
  assign head_valid = full_ff[rd_sel_ff];
  assign head_data = buf_ff[rd_sel_ff];
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_ff <= 2'h0;
      wr_sel_ff <= 1'b0;
      rd_sel_ff <= 1'b0;
      buf_ff[0] <= {W{1'b0}};
      buf_ff[1] <= {W{1'b0}};
    end else begin
      if (push && can_push) begin
        buf_ff[wr_sel_ff] <= push_data;
        full_ff[wr_sel_ff] <= 1'b1;
        wr_sel_ff <= ~wr_sel_ff;
      end
      if (pop && head_valid) begin
        full_ff[rd_sel_ff] <= 1'b0;
        rd_sel_ff <= ~rd_sel_ff;
      end
    end
  end
endmodule
`default_nettype wire

// ---- cmfl_top_sva.sv ----
// Purpose: port checker for cmfl_top
// Assumes: one ref_clk domain
// Notes: bound from the testbench file
`timescale 1ns/10ps
`default_nettype none
module cmfl_top_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host
  input wire logic host_rd,
  input wire logic [3:0] host_slot,
  input wire logic [1:0] host_word,
  input wire logic host_timer_rd,
  input wire logic [15:0] host_rdata_ff,
  // arbitration
  input wire logic arb_chk,
  input wire logic arb_sent,
  input wire logic arb_seen,
  input wire logic arb_lost_ff,
  input wire logic bit_err_ff,
  // status
  input wire logic [3:0] lock_slot_ff,
  input wire logic lock_vld_ff,
  input wire logic [15:0] timer_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_stat_rd;
    host_rd && host_word == 2'h0;
  endsequence
  sequence s_busy_rd;
    s_stat_rd ##1 host_rdata_ff[4] && !host_rdata_ff[7];
  endsequence
  property p_arb_lost;
    arb_chk && arb_sent && !arb_seen |=> arb_lost_ff && !bit_err_ff;
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("no loss");
  property p_bit_err;
    arb_chk && !arb_sent && arb_seen |=> bit_err_ff && !arb_lost_ff;
  endproperty
  a_bit_err: assert property (p_bit_err) else $error("no error");
  property p_arb_ok;
    arb_chk && arb_sent == arb_seen |=> !bit_err_ff && !arb_lost_ff;
  endproperty
  a_arb_ok: assert property (p_arb_ok) else $error("false flag");
  property p_lock_rise;
    $rose(lock_vld_ff) |-> $past(host_rd) && $past(host_word) == 2'h0;
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock");
  property p_lock_move;
    lock_vld_ff && $changed(lock_slot_ff) |->
      $past(host_rd) && $past(host_slot) == lock_slot_ff;
  endproperty
  a_lock_move: assert property (p_lock_move) else $error("move");
  property p_tmr_rel;
    host_timer_rd && !host_rd |=> !lock_vld_ff;
  endproperty
  a_tmr_rel: assert property (p_tmr_rel) else $error("held");
  property p_busy_free;
    s_busy_rd |-> !lock_vld_ff;
  endproperty
  a_busy_free: assert property (p_busy_free) else $error("busy");
  property p_tmr_run;
    !$past(rst) |-> timer_ff == $past(timer_ff) + 16'h0001;
  endproperty
  a_tmr_run: assert property (p_tmr_run) else $error("timer");
endmodule
`default_nettype wire

// ---- cmfl_peer.sv ----
// Purpose: far-side frame source and bit sampler
// Assumes: drives just after rising edges
// Notes: released id lines show the inverted last value
`timescale 1ns/10ps
`default_nettype none
module cmfl_peer (
  // clock
  input wire logic ref_clk,
  // frame
  output logic rx_frame_vld = 1'b0,
  output logic [28:0] rx_id = 29'h0,
  output logic rx_ide = 1'b0,
  output logic rx_srr = 1'b0,
  output logic rx_rtr = 1'b0,
  output logic [3:0] rx_len = 4'h8,
  output logic id_start = 1'b0,
  // arbitration
  output logic arb_chk = 1'b0,
  output logic arb_sent = 1'b0,
  output logic arb_seen = 1'b0
);
  task send(input logic [28:0] id, input logic ide, input logic rtr);
    @(posedge ref_clk);
    id_start <= 1'b1;
    @(posedge ref_clk);
    id_start <= 1'b0;
    rx_frame_vld <= 1'b1;
    rx_id <= id;
    rx_ide <= ide;
    rx_srr <= ide; // recessive as seen on the bus
    rx_rtr <= rtr;
    @(posedge ref_clk);
    rx_frame_vld <= 1'b0;
    rx_id <= ~id;
  endtask
  task arb(input logic s, input logic e);
    @(posedge ref_clk);
    arb_chk <= 1'b1;
    arb_sent <= s;
    arb_seen <= e;
    @(posedge ref_clk);
    arb_chk <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for cmfl_top
// Assumes: FILL_CYCLES 8, so a frame lands within 12 edges
// Notes: one task per scenario
`timescale 1ns/10ps
`default_nettype none
`include "cmfl_defines.vh"
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic host_timer_rd = 1'b0;
  logic [3:0] host_slot = 4'h0;
  logic [1:0] host_word = 2'h0;
  logic [15:0] host_wdata = 16'h0000;
  logic [28:0] mask_global = 29'h1FFFFFFE; // widened and restored in t_lock
  logic [28:0] mask_14 = 29'h17FFFFFF;
  logic [28:0] mask_15 = 29'h1FFFFFFD;
  wire logic vld, ide, srr, rtr, ids, chk_s, snt, sen, lost, berr, lv, rdy;
  wire logic [28:0] rid;
  wire logic [3:0] len, ls;
  wire logic [15:0] rdata, tmv;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [15:0] rv;
  localparam logic [28:0] ID_A = 29'h0ABCDE12;
  always #12.5 ref_clk = ~ref_clk;
  cmfl_peer u_cmfl_peer (.ref_clk, .rx_frame_vld(vld), .rx_id(rid),
    .rx_ide(ide), .rx_srr(srr), .rx_rtr(rtr), .rx_len(len), .id_start(ids),
    .arb_chk(chk_s), .arb_sent(snt), .arb_seen(sen));
  cmfl_top #(.FILL_CYCLES(8)) u_cmfl_top (.ref_clk, .rst, .host_wr,
    .host_rd, .host_slot, .host_word, .host_wdata, .host_rdata_ff(rdata),
    .host_timer_rd, .mask_global, .mask_14, .mask_15,
    .rx_frame_vld(vld), .rx_id(rid), .rx_ide(ide), .rx_srr(srr),
    .rx_rtr(rtr), .rx_len(len), .id_start(ids), .rx_ready_ff(rdy),
    .arb_chk(chk_s), .arb_sent(snt), .arb_seen(sen), .arb_lost_ff(lost),
    .bit_err_ff(berr), .lock_slot_ff(ls), .lock_vld_ff(lv), .timer_ff(tmv));
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_code(input logic [3:0] c);
    chk({12'h0, rv[7:4]}, {12'h0, c});
  endtask
  task gap(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task wr(input logic [3:0] s, input logic [1:0] w, input logic [15:0] d);
    @(posedge ref_clk);
    host_wr <= 1'b1;
    host_slot <= s;
    host_word <= w;
    host_wdata <= d;
    @(posedge ref_clk);
    host_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] s, input logic [1:0] w);
    @(posedge ref_clk);
    host_rd <= 1'b1;
    host_slot <= s;
    host_word <= w;
    @(posedge ref_clk);
    host_rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task tmr;
    @(posedge ref_clk);
    host_timer_rd <= 1'b1;
    @(posedge ref_clk);
    host_timer_rd <= 1'b0;
    #1;
  endtask
  function automatic logic [15:0] up(input logic [28:0] id);
    return {id[28:18], 2'b11, id[17:15]};
  endfunction
  function automatic logic [15:0] lo(input logic [28:0] id);
    return {id[14:0], 1'b0};
  endfunction
  task cfg(input logic [3:0] s, input logic [28:0] id, input logic [3:0] c);
    wr(s, 2'h0, {8'h00, `CMFL_CODE_RX_OFF, 4'h0});
    wr(s, 2'h1, up(id));
    wr(s, 2'h2, lo(id));
    wr(s, 2'h0, {8'h00, c, 4'h0});
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_arb;
    logic [15:0] e;
    for (int i = 0; i < 4; i++) begin
      u_cmfl_peer.arb(i[1], i[0]);
      e = {14'h0, i[1] & ~i[0], ~i[1] & i[0]};
      chk({14'h0, lost, berr}, e);
    end
  endtask
  task t_ext;
    cfg(4'h3, ID_A, `CMFL_CODE_RX_EMPTY);
    u_cmfl_peer.send(ID_A, 1'b1, 1'b0);
    gap(12);
    rd(4'h3, 2'h1);
    chk(rv, up(ID_A));
    rd(4'h3, 2'h2);
    chk(rv, lo(ID_A));
    rd(4'h3, 2'h3);
    chk(rv, 16'h0000);
  endtask
  task t_std;
    wr(4'h2, 2'h1, 16'hFF00);
    wr(4'h2, 2'h0, {8'h00, `CMFL_CODE_RX_EMPTY, 4'h0});
    u_cmfl_peer.send(29'h1FE00000, 1'b1, 1'b0);
    gap(12);
    rd(4'h2, 2'h0);
    chk_code(`CMFL_CODE_RX_EMPTY);
    tmr();
    u_cmfl_peer.send(29'h1FE00000, 1'b0, 1'b0);
    gap(12);
    rd(4'h2, 2'h1);
    chk(rv, 16'hFF00);
    rd(4'h2, 2'h0);
    chk_code(`CMFL_CODE_RX_FULL);
  endtask
  task t_lock;
    rd(4'h3, 2'h0);
    chk({11'h0, lv, ls}, 16'h0013);
    u_cmfl_peer.send(ID_A ^ 29'h1, 1'b1, 1'b0);
    gap(12);
    rd(4'h3, 2'h2);
    chk(rv, lo(ID_A));
    @(posedge ref_clk);
    mask_global <= 29'h1FFFFFFF;
    rd(4'h2, 2'h0);
    chk({11'h0, lv, ls}, 16'h0012);
    gap(12);
    rd(4'h3, 2'h2);
    chk(rv, lo(ID_A ^ 29'h1));
    tmr();
    chk({15'h0, lv}, 16'h0000);
    @(posedge ref_clk);
    mask_global <= 29'h1FFFFFFE;
  endtask
  task t_busy;
    chk({15'h0, rdy}, 16'h0001);
    u_cmfl_peer.send(ID_A, 1'b1, 1'b0);
    gap(2);
    rd(4'h3, 2'h0);
    chk({14'h0, rv[4], lv}, 16'h0002);
    chk_code(`CMFL_CODE_RX_OVR | 4'h1);
    gap(20);
    rd(4'h3, 2'h0);
    chk({15'h0, rv[4]}, 16'h0000);
  endtask
  task t_mask;
    cfg(4'hE, 29'h15555555, `CMFL_CODE_RX_EMPTY);
    u_cmfl_peer.send(29'h1D555555, 1'b1, 1'b0);
    gap(12);
    rd(4'hE, 2'h1);
    chk(rv, up(29'h1D555555));
    cfg(4'hF, 29'h0D555557, `CMFL_CODE_RX_EMPTY);
    u_cmfl_peer.send(29'h0D555555, 1'b1, 1'b0);
    gap(12);
    rd(4'hF, 2'h2);
    chk(rv, lo(29'h0D555555));
    cfg(4'h5, 29'h00001234, `CMFL_CODE_TX_RRESP);
    u_cmfl_peer.send(29'h00001234, 1'b1, 1'b1);
    gap(12);
    rd(4'h5, 2'h0);
    chk_code(`CMFL_CODE_TX_ONCE_RESP);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    gap(2);
    rst <= 1'b0;
    t_arb();
    t_ext();
    t_std();
    t_lock();
    t_busy();
    t_mask();
    report_and_stop();
  end
  // the whole run needs well under a thousand edges
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
endmodule
bind cmfl_top cmfl_top_sva u_cmfl_top_sva (.ref_clk, .rst, .host_rd,
  .host_slot, .host_word, .host_timer_rd, .host_rdata_ff, .arb_chk,
  .arb_sent, .arb_seen, .arb_lost_ff, .bit_err_ff, .lock_slot_ff,
  .lock_vld_ff, .timer_ff);
`default_nettype wire
